// *** logic/txp_access.sv ***
// indirect access logic for the transmit channel provisioning memory
//
// Chosen here: the strobed register port.
`timescale 1ns/1ps
// Function
// - select write starts an indirect access
// - channel field picks the entry
// - direction zero copies data into entry
// - direction one loads entry into data
// - busy high for whole access
// - no byte lanes; all-off enables ignored
// - block pointer names channel fifo ring
// - delineation enables flags, stuffing, check
// - check select, ignored without delineation
// - provision gates servicing assigner requests
// - fields read last written until read
// - read returns provision, check, delineation
// - second data register carries fifo length
module txp_access
   import txp_pkg::*;
(
   input wire logic core_clk, // system clock
   input wire logic resetn, // asynchronous reset, active low
   input wire logic [txp_pkg::TXP_ADDR_W-1:0] reg_addr, // byte address
   input wire logic [txp_pkg::TXP_DATA_W-1:0] reg_wdata, // write data
   input wire logic reg_wr, // write strobe
   input wire logic reg_rd, // read strobe
   input wire logic [3:0] byte_enables_n, // byte enables, active low
   output logic [txp_pkg::TXP_DATA_W-1:0] reg_rdata, // read data
   input wire logic [txp_pkg::TXP_CHAN_W-1:0] cfg_chan, // channel looked up
   output logic cfg_provision, // looked-up provision enable
   output logic cfg_delineate, // flags, stuffing and check on
   output logic [1:0] cfg_crc_mode, // effective check algorithm
   output logic [txp_pkg::TXP_PTR_W-1:0] cfg_fptr, // fifo block pointer
   output logic [txp_pkg::TXP_PTR_W-1:0] cfg_flen, // fifo length blocks
   input wire logic assigner_req, // data request from channel assigner
   input wire logic [txp_pkg::TXP_CHAN_W-1:0] assigner_chan, // its channel
   output logic service_grant // request accepted for servicing
);
   import txp_pkg::*;

   // whole control state of the block
   typedef struct packed {
      txp_state_type state; // sequencer state
      logic [2:0] cnt; // cycles left in the access
      logic busy; // access in progress
      logic dir; // latched direction, 1 = read
      logic [TXP_CHAN_W-1:0] chan; // latched channel
      logic [TXP_RSV_W-1:0] rsv; // reserved select bits
      logic channel_provision_enable; // data one provision enable
      logic [TXP_CRC_W-1:0] crc; // data one check algorithm
      logic delineation_enable; // data one delineation enable
      logic [TXP_PTR_W-1:0] fptr; // data one block pointer
      logic [TXP_PTR_W-1:0] flen; // data two fifo length
      logic [TXP_DATA_W-1:0] rdata; // registered read data
      logic cfg_channel_provision_enable; // lookup provision
      logic cfg_delineation_enable; // lookup delineation
      logic [TXP_CRC_W-1:0] cfg_crc; // lookup effective check
      logic [TXP_PTR_W-1:0] cfg_fptr; // lookup pointer
      logic [TXP_PTR_W-1:0] cfg_flen; // lookup length
      logic grant; // assigner request serviced
   } txp_regs_type;

   txp_regs_type q_r; // registered state
   txp_regs_type q_nxt; // next state

   // one entry per channel number, no reset: software provisions it
   txp_entry_type mem [TXP_CHANNELS];

   logic lanes_on; // at least one byte enable asserted
   logic sel_wr; // accepted select write
   logic d1_wr; // accepted data one write
   logic d2_wr; // accepted data two write
   logic finish; // last cycle of an access
   logic commit; // indirect write lands this cycle
   txp_entry_type sel_entry; // entry of the latched channel
   txp_entry_type cfg_entry; // entry of the looked-up channel
   logic req_channel_provision_enable; // provision bit of the requesting channel

   // no byte lanes: any enable makes a full write, none makes nothing
   assign lanes_on = ~&byte_enables_n;
   // select writes during an access are dropped so it is not corrupted
   assign sel_wr = reg_wr && lanes_on && !q_r.busy
      && reg_addr == TXP_SEL_OFFSET;
   // data writes while busy are dropped too, keeping the access coherent
   assign d1_wr = reg_wr && lanes_on && !q_r.busy
      && reg_addr == TXP_D1_OFFSET;
   assign d2_wr = reg_wr && lanes_on && !q_r.busy
      && reg_addr == TXP_D2_OFFSET;
   assign finish = q_r.state == TXP_RUN && q_r.cnt == 3'h1;
   assign commit = finish && !q_r.dir;
   assign sel_entry = mem[q_r.chan];
   assign cfg_entry = mem[cfg_chan];
   assign req_channel_provision_enable = mem[assigner_chan].channel_provision_enable;

   // indirect write: data registers go into the selected entry
   always_ff @(posedge core_clk) begin
      if (commit) begin
         mem[q_r.chan] <= '{channel_provision_enable: q_r.channel_provision_enable, crc: q_r.crc,
            delineation_enable: q_r.delineation_enable, fptr: q_r.fptr,
            flen: q_r.flen};
      end
   end

   // next-state logic for the sequencer, registers and outputs
   always_comb begin
      logic [TXP_DATA_W-1:0] rd_word; // word for the read mux
      rd_word = TXP_WORD_RST;
      q_nxt = q_r;
      // sequencer
      case (q_r.state)
         TXP_IDLE: begin
            if (sel_wr) begin
               // latch channel and direction from the same write
               q_nxt.state = TXP_RUN;
               q_nxt.cnt = TXP_ACCESS_CYCLES;
               q_nxt.busy = 1'b1;
               q_nxt.dir = reg_wdata[TXP_SEL_DIR_BIT];
               q_nxt.chan = reg_wdata[TXP_SEL_CHAN_LSB +: TXP_CHAN_W];
               q_nxt.rsv = reg_wdata[TXP_SEL_RSV_LSB +: TXP_RSV_W];
            end
         end
         TXP_RUN: begin
            q_nxt.cnt = q_r.cnt - 3'h1;
            if (finish) begin
               q_nxt.state = TXP_IDLE;
               q_nxt.busy = 1'b0;
               if (q_r.dir) begin
                  // indirect read overwrites what the host last wrote
                  q_nxt.channel_provision_enable = sel_entry.channel_provision_enable;
                  q_nxt.crc = sel_entry.crc;
                  q_nxt.delineation_enable = sel_entry.delineation_enable;
                  q_nxt.fptr = sel_entry.fptr;
                  q_nxt.flen = sel_entry.flen;
               end
            end
         end
         default: begin
            q_nxt.state = TXP_IDLE;
            q_nxt.busy = 1'b0;
         end
      endcase
      // host writes to the data registers
      if (d1_wr) begin
         q_nxt.channel_provision_enable = reg_wdata[TXP_D1_CHANNEL_PROVISION_ENABLE_BIT];
         q_nxt.crc = reg_wdata[TXP_D1_CRC_LSB +: TXP_CRC_W];
         q_nxt.delineation_enable = reg_wdata[TXP_D1_DELINEATION_ENABLE_BIT];
         q_nxt.fptr = reg_wdata[TXP_D1_FPTR_LSB +: TXP_PTR_W];
      end
      if (d2_wr) begin
         q_nxt.flen = reg_wdata[TXP_D2_FLEN_LSB +: TXP_PTR_W];
      end
      // read mux; pointer and length are write-only and read as zero
      if (reg_addr == TXP_SEL_OFFSET) begin
         rd_word[TXP_SEL_BUSY_BIT] = q_r.busy;
         rd_word[TXP_SEL_DIR_BIT] = q_r.dir;
         rd_word[TXP_SEL_RSV_LSB +: TXP_RSV_W] = q_r.rsv;
         rd_word[TXP_SEL_CHAN_LSB +: TXP_CHAN_W] = q_r.chan;
      end else if (reg_addr == TXP_D1_OFFSET) begin
         rd_word[TXP_D1_CHANNEL_PROVISION_ENABLE_BIT] = q_r.channel_provision_enable;
         rd_word[TXP_D1_CRC_LSB +: TXP_CRC_W] = q_r.crc;
         rd_word[TXP_D1_DELINEATION_ENABLE_BIT] = q_r.delineation_enable;
      end else begin
         rd_word = TXP_WORD_RST; // data two and unmapped read zero
      end
      // read data stand only in the cycle after the strobe
      if (reg_rd && lanes_on) begin
         q_nxt.rdata = rd_word;
      end else begin
         q_nxt.rdata = TXP_WORD_RST;
      end
      // per-channel settings for the transmitter datapath
      q_nxt.cfg_channel_provision_enable = cfg_entry.channel_provision_enable;
      q_nxt.cfg_delineation_enable = cfg_entry.delineation_enable;
      // check select means nothing without delineation
      q_nxt.cfg_crc = cfg_entry.delineation_enable ? cfg_entry.crc
         : TXP_CRC_NONE;
      q_nxt.cfg_fptr = cfg_entry.fptr;
      q_nxt.cfg_flen = cfg_entry.flen;
      // unprovisioned channels never see their requests answered
      q_nxt.grant = assigner_req && req_channel_provision_enable;
   end

   // state register
   always_ff @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         q_r <= '{state: TXP_IDLE, cnt: 3'h0, busy: 1'b0, dir: 1'b0,
            chan: TXP_CHAN_RST, rsv: 2'h0, channel_provision_enable: 1'b0, crc: TXP_CRC_NONE,
            delineation_enable: 1'b0, fptr: TXP_PTR_RST, flen: TXP_PTR_RST,
            rdata: TXP_WORD_RST, cfg_channel_provision_enable: 1'b0, cfg_delineation_enable: 1'b0,
            cfg_crc: TXP_CRC_NONE, cfg_fptr: TXP_PTR_RST,
            cfg_flen: TXP_PTR_RST, grant: 1'b0};
      end else begin
         q_r <= q_nxt;
      end
   end

   // outputs straight from the state register
   assign reg_rdata = q_r.rdata;
   assign cfg_provision = q_r.cfg_channel_provision_enable;
   assign cfg_delineate = q_r.cfg_delineation_enable;
   assign cfg_crc_mode = q_r.cfg_crc;
   assign cfg_fptr = q_r.cfg_fptr;
   assign cfg_flen = q_r.cfg_flen;
   assign service_grant = q_r.grant;

   // an accepted select write raises busy at the next edge
   property p_busy_set;
      @(posedge core_clk) disable iff (!resetn)
      sel_wr |=> q_r.busy && q_r.chan
         == $past(reg_wdata[TXP_SEL_CHAN_LSB +: TXP_CHAN_W]);
   endproperty
   a_busy_set: assert property (p_busy_set)
      else $error("select write did not start the access");

   // busy stands exactly four cycles then drops
   property p_busy_len;
      @(posedge core_clk) disable iff (!resetn)
      $rose(q_r.busy) |-> q_r.busy [*4] ##1 !q_r.busy;
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("busy length wrong");

   // a write with no byte enable leaves data one alone
   property p_no_lanes;
      @(posedge core_clk) disable iff (!resetn)
      reg_wr && &byte_enables_n && !q_r.busy |=> $stable(q_r.fptr)
         && $stable(q_r.channel_provision_enable) && $stable(q_r.busy);
   endproperty
   a_no_lanes: assert property (p_no_lanes)
      else $error("write without byte enables took effect");

   // host writes during a write access are not taken
   property p_busy_ignore;
      @(posedge core_clk) disable iff (!resetn)
      q_r.busy && !q_r.dir && reg_wr |=> $stable(q_r.fptr)
         && $stable(q_r.flen) && $stable(q_r.chan);
   endproperty
   a_busy_ignore: assert property (p_busy_ignore)
      else $error("write during busy changed state");

   // completed indirect write lands in the selected entry
   property p_commit;
      @(posedge core_clk) disable iff (!resetn)
      commit |=> mem[q_r.chan].fptr == $past(q_r.fptr)
         && mem[q_r.chan].channel_provision_enable == $past(q_r.channel_provision_enable);
   endproperty
   a_commit: assert property (p_commit)
      else $error("indirect write not stored");

   // completed indirect read loads the entry into data one
   property p_read_back;
      @(posedge core_clk) disable iff (!resetn)
      finish && q_r.dir |=> q_r.channel_provision_enable == $past(sel_entry.channel_provision_enable)
         && q_r.crc == $past(sel_entry.crc) && !q_r.busy;
   endproperty
   a_read_back: assert property (p_read_back)
      else $error("indirect read did not load data");

   // read data are zero except after a read strobe
   property p_rd_idle;
      @(posedge core_clk) disable iff (!resetn)
      !reg_rd |=> reg_rdata == TXP_WORD_RST;
   endproperty
   a_rd_idle: assert property (p_rd_idle)
      else $error("read data outside the read slot");

   // check select is forced off without delineation
   property p_crc_gate;
      @(posedge core_clk) disable iff (!resetn)
      !cfg_delineate |-> cfg_crc_mode == TXP_CRC_NONE;
   endproperty
   a_crc_gate: assert property (p_crc_gate)
      else $error("check active without delineation");

   // provisioned channel requests are granted next cycle
   property p_grant;
      @(posedge core_clk) disable iff (!resetn)
      assigner_req && req_channel_provision_enable |=> service_grant;
   endproperty
   a_grant: assert property (p_grant)
      else $error("provisioned request not serviced");

   // a grant always answers a request of a provisioned channel
   property p_grant_cause;
      @(posedge core_clk) disable iff (!resetn)
      service_grant |-> $past(assigner_req) && $past(req_channel_provision_enable);
   endproperty
   a_grant_cause: assert property (p_grant_cause)
      else $error("grant without provisioned request");

   // a read with no byte enable returns nothing
   property p_no_lanes_rd;
      @(posedge core_clk) disable iff (!resetn)
      reg_rd && &byte_enables_n |=> reg_rdata == TXP_WORD_RST;
   endproperty
   a_no_lanes_rd: assert property (p_no_lanes_rd)
      else $error("read without byte enables returned data");

   // writes during any access leave its channel and direction alone; its count still steps down by one
   property p_busy_hold;
      @(posedge core_clk) disable iff (!resetn)
      q_r.busy && reg_wr |=> $stable(q_r.chan) && $stable(q_r.dir)
         && q_r.cnt == $past(q_r.cnt) - 3'h1;
   endproperty
   a_busy_hold: assert property (p_busy_hold)
      else $error("write during busy disturbed the access");
endmodule // txp_access

// *** logic/txp_pkg.sv ***
// constants and types for the transmit channel provisioning access block
package txp_pkg;
   // register byte offsets
   localparam logic [11:0] TXP_SEL_OFFSET = 12'h380; // indirect select
   localparam logic [11:0] TXP_D1_OFFSET = 12'h384; // indirect data one
   localparam logic [11:0] TXP_D2_OFFSET = 12'h388; // indirect data two
   // widths
   localparam int TXP_ADDR_W = 12; // register address width
   localparam int TXP_DATA_W = 32; // register data width
   localparam int TXP_CHAN_W = 8; // channel number width
   localparam int TXP_PTR_W = 11; // block pointer and length width
   localparam int TXP_CRC_W = 2; // check algorithm width
   localparam int TXP_RSV_W = 2; // select reserved field width
   localparam int TXP_CHANNELS = 256; // provisioning entries
   // select register field positions
   localparam int TXP_SEL_CHAN_LSB = 0; // channel number
   localparam int TXP_SEL_RSV_LSB = 8; // reserved read/write pair
   localparam int TXP_SEL_DIR_BIT = 14; // access direction, 1 = read
   localparam int TXP_SEL_BUSY_BIT = 15; // busy flag, read only
   // data one field positions
   localparam int TXP_D1_FPTR_LSB = 0; // fifo block pointer
   localparam int TXP_D1_DELINEATION_ENABLE_BIT = 12; // delineation enable
   localparam int TXP_D1_CRC_LSB = 13; // check algorithm
   localparam int TXP_D1_CHANNEL_PROVISION_ENABLE_BIT = 15; // channel provision enable
   // data two field positions
   localparam int TXP_D2_FLEN_LSB = 0; // fifo length in blocks minus one
   // check algorithm encodings
   localparam logic [1:0] TXP_CRC_NONE = 2'h0; // no check sequence
   localparam logic [1:0] TXP_CRC_CCITT = 2'h1; // 16-bit check
   localparam logic [1:0] TXP_CRC_32 = 2'h2; // 32-bit check
   localparam logic [1:0] TXP_CRC_RSVD = 2'h3; // reserved
   // reset values
   localparam logic [7:0] TXP_CHAN_RST = 8'h00; // channel number
   localparam logic [10:0] TXP_PTR_RST = 11'h000; // pointer and length
   localparam logic [31:0] TXP_WORD_RST = 32'h0000_0000; // read data
   // cycles an indirect access keeps the busy flag high
   localparam logic [2:0] TXP_ACCESS_CYCLES = 3'h4;
   // access sequencer states
   typedef enum logic {TXP_IDLE, TXP_RUN} txp_state_type;
   // one provisioning entry
   typedef struct packed {
      logic channel_provision_enable; // channel provision enable
      logic [1:0] crc; // check algorithm
      logic delineation_enable; // delineation enable
      logic [10:0] fptr; // fifo block pointer
      logic [10:0] flen; // fifo length blocks
   } txp_entry_type;
endpackage

// *** verification/txp_access_bench.sv ***
// self-checking bench for the transmit provisioning access block
`timescale 1ns/1ps
module tx_hdlc_channel_provision_access_bench;
   import txp_pkg::*;
   logic core_clk = 1'b0; // 20 MHz system clock
   logic resetn = 1'b0; // held low for the first cycles
   logic [TXP_ADDR_W-1:0] reg_addr = '0; // bus address
   logic [TXP_DATA_W-1:0] reg_wdata = '0; // bus write data
   logic reg_wr = 1'b0; // write strobe
   logic reg_rd = 1'b0; // read strobe
   logic [3:0] byte_enables_n = 4'h0; // all lanes on by default
   logic [TXP_DATA_W-1:0] reg_rdata; // bus read data
   logic [TXP_CHAN_W-1:0] cfg_chan = '0; // lookup channel
   logic cfg_provision; // looked-up provision enable
   logic cfg_delineate; // looked-up delineation
   logic [1:0] cfg_crc_mode; // looked-up check algorithm
   logic [TXP_PTR_W-1:0] cfg_fptr; // looked-up block pointer
   logic [TXP_PTR_W-1:0] cfg_flen; // looked-up fifo length
   logic assigner_req = 1'b0; // assigner data request
   logic [TXP_CHAN_W-1:0] assigner_chan = '0; // channel of the request
   logic service_grant; // request accepted
   logic [31:0] rd_v; // word caught by the last bus read
   int fails = 0; // mismatches
   int n_tests = 0; // comparisons
   // free-running clock, 50 ns period
   always #25 core_clk = ~core_clk;
   txp_access DUT (.core_clk(core_clk), .resetn(resetn),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .byte_enables_n(byte_enables_n),
      .reg_rdata(reg_rdata), .cfg_chan(cfg_chan),
      .cfg_provision(cfg_provision), .cfg_delineate(cfg_delineate),
      .cfg_crc_mode(cfg_crc_mode), .cfg_fptr(cfg_fptr), .cfg_flen(cfg_flen),
      .assigner_req(assigner_req), .assigner_chan(assigner_chan),
      .service_grant(service_grant));
   // one comparison; four-state so an unknown never matches
   task automatic check(input string what, input logic [31:0] seen,
      input logic [31:0] exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // verdict and end of run, shared with the watchdog
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // single-cycle write strobe
   task automatic bus_wr(input logic [11:0] a, input logic [31:0] d,
      input logic [3:0] be = 4'h0);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      byte_enables_n <= be;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
      byte_enables_n <= 4'h0;
   endtask
   // single-cycle read strobe; data taken in the cycle after it only
   task automatic bus_rd(input logic [11:0] a, input logic [3:0] be = 4'h0);
      @(posedge core_clk);
      reg_addr <= a;
      byte_enables_n <= be;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      byte_enables_n <= 4'h0;
      #1;
      rd_v = reg_rdata;
   endtask
   // host polls busy before trusting results
   task automatic wait_idle;
      int i;
      for (i = 0; i < 20; i++) begin
         bus_rd(TXP_SEL_OFFSET);
         if (rd_v[TXP_SEL_BUSY_BIT] === 1'b0) break;
      end
      check("busy clears", i < 20, 1'b1);
   endtask
   // data one image; reserved bit eleven always zero
   function automatic logic [31:0] d1(input logic p, input logic [1:0] c,
      input logic dl, input logic [10:0] fp);
      return {16'h0000, p, c, dl, 1'b0, fp};
   endfunction
   // full indirect write, data loaded before the trigger
   task automatic ind_wr(input logic [7:0] ch, input logic [31:0] w1,
      input logic [31:0] w2);
      bus_wr(TXP_D1_OFFSET, w1);
      bus_wr(TXP_D2_OFFSET, w2);
      bus_wr(TXP_SEL_OFFSET, {24'h000000, ch});
      wait_idle();
   endtask
   // lookup and assigner request on one channel, seen one cycle later
   task automatic look(input logic [7:0] ch, input logic p, input logic dl,
      input logic [1:0] c, input logic [10:0] fp, input logic [10:0] fl);
      @(posedge core_clk);
      cfg_chan <= ch;
      assigner_chan <= ch;
      assigner_req <= 1'b1;
      @(posedge core_clk);
      assigner_req <= 1'b0;
      #1;
      check("cfg_provision", cfg_provision, p);
      check("service_grant", service_grant, p);
      check("cfg_delineate", cfg_delineate, dl);
      check("cfg_crc_mode", cfg_crc_mode, c);
      check("cfg_fptr", cfg_fptr, fp);
      check("cfg_flen", cfg_flen, fl);
   endtask
   // registers come out of reset cleared, busy low
   task automatic t_reset;
      bus_rd(TXP_SEL_OFFSET);
      check("select after reset", rd_v, 32'h0000_0000);
      bus_rd(TXP_D1_OFFSET);
      check("data one after reset", rd_v, 32'h0000_0000);
   endtask
   // top channel written; busy sampled at fixed points of the access
   task automatic t_write;
      bus_wr(TXP_D1_OFFSET, d1(1'b1, TXP_CRC_CCITT, 1'b1, 11'h7ff));
      bus_wr(TXP_D2_OFFSET, 32'h0000_05a5);
      bus_wr(TXP_SEL_OFFSET, 32'h0000_00ff);
      bus_rd(TXP_SEL_OFFSET);
      check("busy early", rd_v, 32'h0000_80ff);
      bus_rd(TXP_SEL_OFFSET);
      check("busy late", rd_v, 32'h0000_80ff);
      bus_rd(TXP_SEL_OFFSET);
      check("busy done", rd_v, 32'h0000_00ff);
      look(8'hff, 1'b1, 1'b1, TXP_CRC_CCITT, 11'h7ff, 11'h5a5);
   endtask
   // every check code, then delineation off masks the code
   task automatic t_crc;
      for (int m = 0; m < 4; m++) begin
         ind_wr(8'h01, d1(1'b0, m[1:0], 1'b1, 11'h00f), 32'h0000_0001);
         look(8'h01, 1'b0, 1'b1, m[1:0], 11'h00f, 11'h001);
      end
      ind_wr(8'h01, d1(1'b0, TXP_CRC_32, 1'b0, 11'h00f), 32'h0000_0001);
      look(8'h01, 1'b0, 1'b0, TXP_CRC_NONE, 11'h00f, 11'h001);
      look(8'hff, 1'b1, 1'b1, TXP_CRC_CCITT, 11'h7ff, 11'h5a5);
   endtask
   // data one keeps the host value until an indirect read replaces it
   task automatic t_read;
      bus_wr(TXP_D1_OFFSET, d1(1'b0, TXP_CRC_RSVD, 1'b0, 11'h123));
      bus_rd(TXP_D1_OFFSET);
      check("data one as written", rd_v, 32'h0000_6000);
      bus_wr(TXP_SEL_OFFSET, 32'h0000_40ff);
      wait_idle();
      bus_rd(TXP_D1_OFFSET);
      check("data one read back", rd_v, 32'h0000_b000);
      bus_rd(TXP_SEL_OFFSET);
      check("select read back", rd_v, 32'h0000_40ff);
   endtask
   // no byte lanes: one lane enabled writes all, none enabled does nothing
   task automatic t_lanes;
      bus_wr(TXP_D1_OFFSET, 32'h0000_6000, 4'hf);
      bus_rd(TXP_D1_OFFSET);
      check("no lanes write", rd_v, 32'h0000_b000);
      bus_wr(TXP_D1_OFFSET, 32'h0000_9000, 4'he);
      bus_rd(TXP_D1_OFFSET);
      check("one lane write", rd_v, 32'h0000_9000);
      bus_rd(TXP_SEL_OFFSET, 4'hf);
      check("no lanes read", rd_v, 32'h0000_0000);
   endtask
   // writes landing while busy must not disturb the running access
   task automatic t_busy;
      bus_wr(TXP_D1_OFFSET, d1(1'b1, TXP_CRC_32, 1'b1, 11'h0aa));
      bus_wr(TXP_D2_OFFSET, 32'h0000_0111);
      bus_wr(TXP_SEL_OFFSET, 32'h0000_0002);
      bus_wr(TXP_D1_OFFSET, 32'h0000_0000);
      bus_wr(TXP_SEL_OFFSET, 32'h0000_4003);
      wait_idle();
      bus_rd(TXP_D1_OFFSET);
      check("data one kept", rd_v, 32'h0000_d000);
      bus_rd(TXP_SEL_OFFSET);
      check("select kept", rd_v, 32'h0000_0002);
      look(8'h02, 1'b1, 1'b1, TXP_CRC_32, 11'h0aa, 11'h111);
   endtask
   // the unmapped word next to data two reads zero and stores nothing
   task automatic t_unmapped;
      bus_rd(12'h38c);
      check("unmapped read", rd_v, 32'h0000_0000);
      bus_wr(12'h38c, 32'hffff_ffff);
      bus_rd(TXP_D1_OFFSET);
      check("unmapped write", rd_v, 32'h0000_d000);
      // read data must fall back to zero once the read slot is over
      @(posedge core_clk);
      #1;
      check("read slot over", reg_rdata, 32'h0000_0000);
      // fifo length is write-only, so data two reads zero
      bus_rd(TXP_D2_OFFSET);
      check("data two reads zero", rd_v, 32'h0000_0000);
   endtask
   // main sequence: reset for five cycles, then the scenarios
   initial begin
      repeat (5) @(posedge core_clk);
      resetn <= 1'b1;
      t_reset();
      t_write();
      t_crc();
      t_read();
      t_lanes();
      t_busy();
      t_unmapped();
      tally_and_finish();
   end
   // watchdog, far beyond the roughly 150 cycles the run needs
   initial begin
      repeat (20000) @(posedge core_clk);
      fails++;
      tally_and_finish();
   end
endmodule // tx_hdlc_channel_provision_access_bench
